// ===== rtl/pdc_divider_ctrl.sv
// loop pump, power-down and divider control registers with the dividers
// Function
// R1 - pump mode field selects pump drive state
// R2 - power-down field; loop runs only at 00
// R3 - reference divider 14 bits, low byte 0x01
// R4 - reference high six bits, reset 0x00
// R5 - swallow counter six bits, reset 0x00
// R6 - main counter 13 bits, low byte 0x03
// R7 - main counter high five bits, reset 0x00
// R8 - control bit 6 holds reference divider reset
// R9 - control bit 5 holds swallow, main reset
// R10 - control bit 4 holds all counters reset
// R11 - control bit 3 makes main divide by one
// R12 - software bypasses only with fixed prescaler
// R13 - prescaler settings classed dual or fixed
// R14 - control bit 7 forces pump mid supply
`timescale 1ns/1ps
`include "pdc_regs.svh"

module pdc_divider_ctrl (
  input  wire logic       ref_clk_i,
  input  wire logic       rst_i,
  input  wire logic       wr_en_i,
  input  wire logic       rd_en_i,
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wr_data_i,
  input  wire logic [2:0] prescaler_sel_i,
  input  wire logic       ref_tick_i,
  input  wire logic       fb_tick_i,
  output logic      [7:0] rd_data_o,
  output logic      [1:0] pump_drive_state_o,
  output logic            pump_up_o,
  output logic            pump_down_o,
  output logic            pump_hiz_o,
  output logic            pump_mid_supply_o,
  output logic            loop_active_o,
  output logic            ref_div_pulse_o,
  output logic            fb_div_pulse_o,
  output logic            modulus_hi_o,
  output logic            bypass_fault_o
);

  // ---------------------------------------------------------------
  // register bank
  // ---------------------------------------------------------------
  pdc_pkg::pdc_pump_t          pump_mode_r;
  pdc_pkg::pdc_pwr_t           pwr_mode_r;
  logic [7:0]                  ref_lo_r;
  logic [`PDC_REF_HI_W-1:0]    ref_hi_r;
  logic [`PDC_SWALLOW_W-1:0]   swallow_r;
  logic [7:0]                  main_lo_r;
  logic [`PDC_MAIN_HI_W-1:0]   main_hi_r;
  logic [4:0]                  ctl_r;
  logic [7:0]                  rd_nxt;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      pump_mode_r <= pdc_pkg::pdc_pump_t'(`PDC_RST_PUMP_MODE); // R1
      pwr_mode_r  <= pdc_pkg::pdc_pwr_t'(`PDC_RST_PWR_MODE); // R2
      ref_lo_r    <= `PDC_RST_REF_LO; // R3
      ref_hi_r    <= `PDC_RST_REF_HI; // R4
      swallow_r   <= `PDC_RST_SWALLOW; // R5
      main_lo_r   <= `PDC_RST_MAIN_LO; // R6
      main_hi_r   <= `PDC_RST_MAIN_HI; // R7
      ctl_r       <= `PDC_RST_CTL;
    end else if (wr_en_i) begin
      case (addr_i)
        `PDC_OFS_PUMP_PWR: begin
          pump_mode_r <= pdc_pkg::pdc_pump_t'(
                         wr_data_i[`PDC_PUMP_MSB:`PDC_PUMP_LSB]); // R1
          pwr_mode_r  <= pdc_pkg::pdc_pwr_t'(
                         wr_data_i[`PDC_PWR_MSB:`PDC_PWR_LSB]); // R2
        end
        `PDC_OFS_REF_LO:  ref_lo_r  <= wr_data_i; // R3
        `PDC_OFS_REF_HI:  ref_hi_r  <= wr_data_i[`PDC_REF_HI_W-1:0]; // R4
        `PDC_OFS_SWALLOW: swallow_r <= wr_data_i[`PDC_SWALLOW_W-1:0]; // R5
        `PDC_OFS_MAIN_LO: main_lo_r <= wr_data_i; // R6
        `PDC_OFS_MAIN_HI: main_hi_r <= wr_data_i[`PDC_MAIN_HI_W-1:0]; // R7
        `PDC_OFS_RST_BYP: ctl_r <= wr_data_i[`PDC_BIT_MID_SUPPLY:
                                             `PDC_BIT_BYPASS];
        default: ;
      endcase
    end
  end

  // unused bits and unmapped offsets read as zero
  always_comb begin
    rd_nxt = 8'h00;
    case (addr_i)
      `PDC_OFS_PUMP_PWR: rd_nxt = {4'h0, pump_mode_r, pwr_mode_r};
      `PDC_OFS_REF_LO:   rd_nxt = ref_lo_r;
      `PDC_OFS_REF_HI:   rd_nxt = {2'h0, ref_hi_r};
      `PDC_OFS_SWALLOW:  rd_nxt = {2'h0, swallow_r};
      `PDC_OFS_MAIN_LO:  rd_nxt = main_lo_r;
      `PDC_OFS_MAIN_HI:  rd_nxt = {3'h0, main_hi_r};
      `PDC_OFS_RST_BYP:  rd_nxt = {ctl_r, 3'h0};
      default:           rd_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      rd_data_o <= 8'h00;
    end else if (rd_en_i) begin
      rd_data_o <= rd_nxt;
    end
  end

  // ---------------------------------------------------------------
  // decoded controls
  // ---------------------------------------------------------------
  localparam int CTL_MID = `PDC_BIT_MID_SUPPLY - `PDC_BIT_BYPASS;
  localparam int CTL_RR  = `PDC_BIT_RST_REF - `PDC_BIT_BYPASS;
  localparam int CTL_RF  = `PDC_BIT_RST_FB - `PDC_BIT_BYPASS;
  localparam int CTL_RA  = `PDC_BIT_RST_ALL - `PDC_BIT_BYPASS;
  localparam int CTL_BY  = 0;

  logic [13:0] ref_div;
  logic [12:0] main_div;
  logic        loop_on;
  logic        ref_hold;
  logic        fb_hold;
  logic        bypass;
  logic        dual_mod;

  assign ref_div  = {ref_hi_r, ref_lo_r}; // R3 R4
  assign main_div = {main_hi_r, main_lo_r}; // R6 R7
  assign loop_on  = (pwr_mode_r == pdc_pkg::PDC_PWR_NORMAL); // R2
  assign ref_hold = ctl_r[CTL_RR] | ctl_r[CTL_RA] | ~loop_on; // R8 R10
  assign fb_hold  = ctl_r[CTL_RF] | ctl_r[CTL_RA] | ~loop_on; // R9 R10
  assign bypass   = ctl_r[CTL_BY];

  // fixed settings are 000, 001 and 111; the rest are dual modulus
  always_comb begin
    case (prescaler_sel_i)
      3'h0, 3'h1, 3'h7: dual_mod = 1'b0; // R13
      default:          dual_mod = 1'b1; // R13
    endcase
  end

  // ---------------------------------------------------------------
  // pump and power outputs
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      pump_drive_state_o <= `PDC_RST_PUMP_MODE;
      pump_up_o          <= 1'b0;
      pump_down_o        <= 1'b0;
      pump_hiz_o         <= 1'b0;
    end else begin
      pump_drive_state_o <= pump_mode_r;
      pump_up_o          <= 1'b0;
      pump_down_o        <= 1'b0;
      pump_hiz_o         <= 1'b0;
      case (pump_mode_r)
        pdc_pkg::PDC_PUMP_HIZ:  pump_hiz_o  <= 1'b1; // R1
        pdc_pkg::PDC_PUMP_UP:   pump_up_o   <= 1'b1; // R1
        pdc_pkg::PDC_PUMP_DOWN: pump_down_o <= 1'b1; // R1
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      pump_mid_supply_o <= 1'b0;
      loop_active_o     <= 1'b0;
      bypass_fault_o    <= 1'b0;
    end else begin
      pump_mid_supply_o <= ctl_r[CTL_MID]; // R14
      loop_active_o     <= loop_on; // R2
      // flags a bypass that software set against a dual setting
      bypass_fault_o    <= bypass & dual_mod; // R12 R13
    end
  end

  // ---------------------------------------------------------------
  // reference divider
  // ---------------------------------------------------------------
  logic [13:0] ref_cnt_r;
  logic        ref_last;

  // a zero count behaves as divide by one
  assign ref_last = (14'(ref_cnt_r + 14'h0001) >= ref_div);

  always_ff @(posedge ref_clk_i) begin
    if (rst_i || ref_hold) begin
      ref_cnt_r       <= 14'h0000; // R8 R10
      ref_div_pulse_o <= 1'b0;
    end else begin
      ref_div_pulse_o <= 1'b0;
      if (ref_tick_i) begin
        if (ref_last) begin
          ref_cnt_r       <= 14'h0000;
          ref_div_pulse_o <= 1'b1; // R3
        end else begin
          ref_cnt_r <= 14'(ref_cnt_r + 14'h0001);
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // feedback divider: swallow phase then main phase
  // ---------------------------------------------------------------
  pdc_pkg::pdc_fb_state_t      fb_state_r;
  logic [12:0]                 main_cnt_r;
  logic [`PDC_SWALLOW_W-1:0]   sw_cnt_r;
  logic                        main_last;
  logic                        sw_last;
  logic                        use_swallow;

  assign main_last   = (13'(main_cnt_r + 13'h0001) >= main_div);
  assign sw_last     = (6'(sw_cnt_r + 6'h01) >= swallow_r);
  assign use_swallow = dual_mod & ~bypass & (swallow_r != 6'h00);

  always_ff @(posedge ref_clk_i) begin
    if (rst_i || fb_hold) begin
      fb_state_r     <= pdc_pkg::PDC_FB_SWALLOW; // R9 R10
      main_cnt_r     <= 13'h0000; // R9 R10
      sw_cnt_r       <= 6'h00; // R9 R10
      fb_div_pulse_o <= 1'b0;
      modulus_hi_o   <= 1'b0;
    end else begin
      fb_div_pulse_o <= 1'b0;
      modulus_hi_o   <= use_swallow &
                        (fb_state_r == pdc_pkg::PDC_FB_SWALLOW); // R5
      if (fb_tick_i) begin
        if (bypass) begin
          fb_div_pulse_o <= 1'b1; // R11
          main_cnt_r     <= 13'h0000;
          sw_cnt_r       <= 6'h00;
          fb_state_r     <= pdc_pkg::PDC_FB_SWALLOW;
        end else if (main_last) begin
          fb_div_pulse_o <= 1'b1; // R6
          main_cnt_r     <= 13'h0000;
          sw_cnt_r       <= 6'h00;
          fb_state_r     <= pdc_pkg::PDC_FB_SWALLOW;
        end else begin
          main_cnt_r <= 13'(main_cnt_r + 13'h0001);
          case (fb_state_r)
            pdc_pkg::PDC_FB_SWALLOW: begin
              if (!use_swallow || sw_last) begin
                fb_state_r <= pdc_pkg::PDC_FB_MAIN; // R5
              end else begin
                sw_cnt_r <= 6'(sw_cnt_r + 6'h01);
              end
            end
            default: ;
          endcase
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  sequence write_ctl_s;
    wr_en_i && addr_i == `PDC_OFS_RST_BYP;
  endsequence

  pump_up_decode_a: assert property ( // R1
    pump_mode_r == pdc_pkg::PDC_PUMP_UP |=> pump_up_o && !pump_down_o
                                            && !pump_hiz_o)
    else $error("pump up mode not decoded");

  pump_normal_a: assert property ( // R1
    pump_mode_r == pdc_pkg::PDC_PUMP_NORMAL |=>
      !pump_up_o && !pump_down_o && !pump_hiz_o)
    else $error("normal pump mode drives a forced state");

  loop_active_a: assert property ( // R2
    pwr_mode_r != pdc_pkg::PDC_PWR_NORMAL |=> !loop_active_o
                                              && main_cnt_r == 13'h0000)
    else $error("loop active while powered down");

  ref_hold_a: assert property ( // R8
    ctl_r[CTL_RR] |=> ref_cnt_r == 14'h0000 && !ref_div_pulse_o)
    else $error("reference divider runs while held");

  fb_hold_a: assert property ( // R9
    ctl_r[CTL_RF] |=> sw_cnt_r == 6'h00 && !fb_div_pulse_o)
    else $error("feedback counters run while held");

  all_hold_a: assert property ( // R10
    ctl_r[CTL_RA] |=> ref_cnt_r == 14'h0000 && main_cnt_r == 13'h0000)
    else $error("counters run under common reset");

  bypass_div_a: assert property ( // R11
    !fb_hold && bypass && fb_tick_i |=> fb_div_pulse_o)
    else $error("bypass did not divide by one");

  ref_period_a: assert property ( // R3
    ref_div == 14'h0002 && !ref_hold && ref_tick_i && ref_cnt_r == 14'h0000
    ##1 !ref_hold && ref_tick_i && $stable(ref_div) |=> ref_div_pulse_o)
    else $error("reference divide by two missed");

  mid_supply_a: assert property ( // R14
    write_ctl_s |=> ##1 pump_mid_supply_o == $past(wr_data_i[7], 2))
    else $error("mid supply output wrong after write");

  bypass_class_a: assert property ( // R13
    bypass && prescaler_sel_i == 3'h7 |=> !bypass_fault_o)
    else $error("fixed setting flagged as dual");

  hi_bits_zero_a: assert property ( // R7
    rd_en_i && addr_i == `PDC_OFS_MAIN_HI |=> rd_data_o[7:5] == 3'h0)
    else $error("unused main high bits read nonzero");

endmodule

// ===== rtl/pdc_pkg.sv
// types shared by the loop divider control bank
package pdc_pkg;

  typedef enum logic [1:0] {
    PDC_PUMP_HIZ,
    PDC_PUMP_UP,
    PDC_PUMP_DOWN,
    PDC_PUMP_NORMAL
  } pdc_pump_t;

  typedef enum logic [1:0] {
    PDC_PWR_NORMAL,
    PDC_PWR_ASYNC_PD,
    PDC_PWR_UNUSED,
    PDC_PWR_SYNC_PD
  } pdc_pwr_t;

  typedef enum logic {
    PDC_FB_SWALLOW,
    PDC_FB_MAIN
  } pdc_fb_state_t;

endpackage

// ===== rtl/pdc_regs.svh
// register offsets, field positions and reset values of the loop control bank
`ifndef PDC_REGS_SVH
`define PDC_REGS_SVH

// ---------------------------------------------------------------
// offsets
// ---------------------------------------------------------------
`define PDC_OFS_PUMP_PWR   8'h10
`define PDC_OFS_REF_LO     8'h11
`define PDC_OFS_REF_HI     8'h12
`define PDC_OFS_SWALLOW    8'h13
`define PDC_OFS_MAIN_LO    8'h14
`define PDC_OFS_MAIN_HI    8'h15
`define PDC_OFS_RST_BYP    8'h16

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define PDC_RST_PUMP_MODE  2'h3
`define PDC_RST_PWR_MODE   2'h1
`define PDC_RST_REF_LO     8'h01
`define PDC_RST_REF_HI     6'h00
`define PDC_RST_SWALLOW    6'h00
`define PDC_RST_MAIN_LO    8'h03
`define PDC_RST_MAIN_HI    5'h00
`define PDC_RST_CTL        5'h00

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define PDC_PUMP_MSB       3
`define PDC_PUMP_LSB       2
`define PDC_PWR_MSB        1
`define PDC_PWR_LSB        0
`define PDC_BIT_MID_SUPPLY 7
`define PDC_BIT_RST_REF    6
`define PDC_BIT_RST_FB     5
`define PDC_BIT_RST_ALL    4
`define PDC_BIT_BYPASS     3
`define PDC_REF_HI_W       6
`define PDC_SWALLOW_W      6
`define PDC_MAIN_HI_W      5

`endif

// ===== tb/pdc_divider_ctrl_tb.sv
// self-checking bench of the loop divider control bank
`timescale 1ns/1ps
`include "pdc_regs.svh"
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin failures++; \
  $display("[FAIL] %s exp %0h got %0h", n, e, g); end end

module pdc_divider_ctrl_tb;
  logic       ref_clk_i       = 1'b0;
  logic       rst_i           = 1'b1;
  logic       wr_en_i         = 1'b0;
  logic       rd_en_i         = 1'b0;
  logic       tick_en         = 1'b0;
  logic [7:0] addr_i          = 8'h00;
  logic [7:0] wr_data_i       = 8'h00;
  logic [2:0] prescaler_sel_i = 3'h0;
  logic       ref_tick, fb_tick;
  logic [7:0] rd_data_o;
  logic [1:0] pump_drive_state_o;
  logic       pump_up_o, pump_down_o, pump_hiz_o, pump_mid_supply_o;
  logic       loop_active_o, ref_div_pulse_o, fb_div_pulse_o;
  logic       modulus_hi_o, bypass_fault_o;
  logic [7:0] rv;
  int         failures = 0;
  int         checks   = 0;
  int         n;
  logic [7:0] ofs  [7] = '{8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16};
  logic [7:0] rstv [7] = '{8'h0D, 8'h01, 8'h00, 8'h00, 8'h03, 8'h00, 8'h00};
  logic [7:0] mask [7] = '{8'h0F, 8'hFF, 8'h3F, 8'h3F, 8'hFF, 8'h1F, 8'hF8};
  logic [7:0] h16  [4] = '{8'h40, 8'h20, 8'h10, 8'h00};
  logic [7:0] h10  [4] = '{8'h0C, 8'h0C, 8'h0C, 8'h0D};
  logic [3:0] ref_held = 4'b1101;
  logic [3:0] fb_held  = 4'b1110;

  always #50 ref_clk_i = ~ref_clk_i;

  pdc_tick_source i_pdc_tick_source (
    .clk_i      (ref_clk_i),
    .en_i       (tick_en),
    .ref_tick_o (ref_tick),
    .fb_tick_o  (fb_tick)
  );

  pdc_divider_ctrl i_pdc_divider_ctrl (
    .ref_clk_i          (ref_clk_i),
    .rst_i              (rst_i),
    .wr_en_i            (wr_en_i),
    .rd_en_i            (rd_en_i),
    .addr_i             (addr_i),
    .wr_data_i          (wr_data_i),
    .prescaler_sel_i    (prescaler_sel_i),
    .ref_tick_i         (ref_tick),
    .fb_tick_i          (fb_tick),
    .rd_data_o          (rd_data_o),
    .pump_drive_state_o (pump_drive_state_o),
    .pump_up_o          (pump_up_o),
    .pump_down_o        (pump_down_o),
    .pump_hiz_o         (pump_hiz_o),
    .pump_mid_supply_o  (pump_mid_supply_o),
    .loop_active_o      (loop_active_o),
    .ref_div_pulse_o    (ref_div_pulse_o),
    .fb_div_pulse_o     (fb_div_pulse_o),
    .modulus_hi_o       (modulus_hi_o),
    .bypass_fault_o     (bypass_fault_o)
  );

  // ---------------------------------------------------------------
  // bus and measurement tasks
  // ---------------------------------------------------------------
  task automatic end_of_test();
    if (failures == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic step(input int c);
    repeat (c) @(posedge ref_clk_i);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    step(1);
    addr_i    = a;
    wr_data_i = d;
    wr_en_i   = 1'b1;
    step(1);
    wr_en_i   = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    step(1);
    addr_i  = a;
    rd_en_i = 1'b1;
    step(1);
    rd_en_i = 1'b0;
    step(1);
    d = rd_data_o;
  endtask

  function automatic logic pulse(input logic f);
    return f ? fb_div_pulse_o : ref_div_pulse_o;
  endfunction

  // cycles from one divider pulse to the next, ticks arriving every cycle
  task automatic period(input logic f, output int k);
    int w;
    w = 0;
    while (pulse(f) !== 1'b1 && w < 600) begin
      step(1);
      w++;
    end
    // a missing pulse is counted here; the run closes in one place
    if (w == 600) begin
      failures++;
      k = 0;
      return;
    end
    k = 0;
    do begin
      step(1);
      k++;
    end while (pulse(f) !== 1'b1 && k < 600);
  endtask

  task automatic count(input logic f, output int k);
    k = 0;
    repeat (20) begin
      step(1);
      if (pulse(f) === 1'b1) k++;
    end
  endtask

  // counters held while both halves change, so no stale count runs on
  task automatic cfg(input logic [13:0] r, input logic [12:0] b);
    wr(`PDC_OFS_RST_BYP, 8'h10);
    wr(`PDC_OFS_REF_LO, r[7:0]);
    wr(`PDC_OFS_REF_HI, {2'h0, r[13:8]});
    wr(`PDC_OFS_MAIN_LO, b[7:0]);
    wr(`PDC_OFS_MAIN_HI, {3'h0, b[12:8]});
    wr(`PDC_OFS_RST_BYP, 8'h00);
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    step(8);
    rst_i = 1'b0;
    for (int i = 0; i < 7; i++) begin
      rd(ofs[i], rv);
      `CHK("reset value", rstv[i], rv)
    end
    `CHK("loop active", 1'b0, loop_active_o)
    for (int i = 0; i < 7; i++) wr(ofs[i], 8'hFF);
    wr(8'h17, 8'hFF);
    for (int i = 0; i < 7; i++) begin
      rd(ofs[i], rv);
      `CHK("readback", mask[i], rv)
    end
    rd(8'h17, rv);
    `CHK("unmapped", 8'h00, rv)
    wr(`PDC_OFS_RST_BYP, 8'h00);
    for (int m = 0; m < 4; m++) begin
      wr(`PDC_OFS_PUMP_PWR, {4'h0, m[1:0], m[1:0]});
      step(2);
      `CHK("pump state", m[1:0], pump_drive_state_o)
      `CHK("pump up", (m == 1), pump_up_o)
      `CHK("pump down", (m == 2), pump_down_o)
      `CHK("pump hiz", (m == 0), pump_hiz_o)
      `CHK("loop active", (m == 0), loop_active_o)
    end
    wr(`PDC_OFS_RST_BYP, 8'h80);
    step(2);
    `CHK("mid supply", 1'b1, pump_mid_supply_o)
    wr(`PDC_OFS_RST_BYP, 8'h00);
    step(2);
    `CHK("mid supply", 1'b0, pump_mid_supply_o)
    wr(`PDC_OFS_PUMP_PWR, 8'h0C);
    tick_en = 1'b1;
    cfg(14'h0102, 13'h0105);
    period(1'b0, n);
    `CHK("ref period", 258, n)
    period(1'b1, n);
    `CHK("fb period", 261, n)
    cfg(14'h0003, 13'h0004);
    period(1'b0, n);
    `CHK("ref period", 3, n)
    period(1'b1, n);
    `CHK("fb period", 4, n)
    wr(`PDC_OFS_RST_BYP, 8'h08);
    period(1'b1, n);
    `CHK("bypass period", 1, n)
    // software keeps the bypass to fixed settings except in this sweep
    for (int s = 0; s < 8; s++) begin
      prescaler_sel_i = s[2:0];
      step(2);
      `CHK("bypass fault", !(s inside {0, 1, 7}), bypass_fault_o)
    end
    prescaler_sel_i = 3'h0;
    for (int i = 0; i < 4; i++) begin
      wr(`PDC_OFS_RST_BYP, h16[i]);
      wr(`PDC_OFS_PUMP_PWR, h10[i]);
      step(3);
      count(1'b0, n);
      `CHK("ref held", ref_held[i], (n == 0))
      count(1'b1, n);
      `CHK("fb held", fb_held[i], (n == 0))
    end
    // dual setting, swallow count two: four ticks a period, two high
    wr(`PDC_OFS_PUMP_PWR, 8'h0C);
    wr(`PDC_OFS_SWALLOW, 8'h02);
    prescaler_sel_i = 3'h2;
    cfg(14'h0002, 13'h0004);
    period(1'b0, n);
    `CHK("ref period", 2, n)
    period(1'b1, n);
    `CHK("dual fb period", 4, n)
    n = 0;
    repeat (20) begin
      step(1);
      if (modulus_hi_o === 1'b1) n++;
    end
    `CHK("modulus high", 10, n)
    end_of_test();
  end
endmodule

// ===== tb/pdc_tick_source.sv
// tick source standing in for the reference input and prescaler output
`timescale 1ns/1ps

module pdc_tick_source (
  input  wire logic clk_i,
  input  wire logic en_i,
  output logic      ref_tick_o,
  output logic      fb_tick_o
);
  // one tick every cycle, the fastest rate the dividers must accept
  always @(posedge clk_i) begin
    ref_tick_o <= #1 en_i;
    fb_tick_o  <= #1 en_i;
  end

  initial begin
    ref_tick_o = 1'b0;
    fb_tick_o  = 1'b0;
  end
endmodule
